//--- src/dcc_defs.svh
// constants for the channel code correction engine
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define DCC_NUM_CH 8
`define DCC_CODE_W 16
`define DCC_ADDR_W 8

// ----------------------------------------------------------------
// address map: region in addr[7:4], channel in addr[2:0]
// ----------------------------------------------------------------
`define DCC_RGN_INPUT 4'h0
`define DCC_RGN_GAIN 4'h1
`define DCC_RGN_ZERO 4'h2
`define DCC_RGN_DATA 4'h3
`define DCC_ADDR_OFFSET_A 8'h40
`define DCC_ADDR_OFFSET_B 8'h41
`define DCC_ADDR_CONFIG 8'h50
`define DCC_ADDR_STATUS 8'h51

// ----------------------------------------------------------------
// config and status fields
// ----------------------------------------------------------------
`define DCC_CFG_ENABLE_BIT 0
`define DCC_CFG_GAIN4_BIT 1
`define DCC_STAT_BUSY_BIT 0
`define DCC_CFG_RESET 16'h0000

// ----------------------------------------------------------------
// reset values and arithmetic constants
// ----------------------------------------------------------------
`define DCC_GAIN_RESET 16'h8000
`define DCC_ZERO_RESET 16'h0000
`define DCC_INPUT_RESET 16'h0000
`define DCC_DATA_RESET 16'h0000
`define DCC_GAIN_BIAS 17'h08000
`define DCC_SIGN_FLIP 16'h8000
`define DCC_TRIM_G6 16'h999A
`define DCC_TRIM_G4 16'hAAAB
`define DCC_SAT_MAX 16'hFFFF
`define DCC_SAT_MIN 16'h0000

`endif

//--- src/dcc_pkg.sv
// types for the channel code correction engine
package dcc_pkg;

// ----------------------------------------------------------------
// engine states
// ----------------------------------------------------------------
typedef enum logic [2:0] {
    DCC_IDLE = 3'b001,
    DCC_MUL = 3'b010,
    DCC_STORE = 3'b100
} dcc_state_e;

typedef logic [15:0] dcc_code_t;
typedef logic [7:0] dcc_addr_t;
typedef logic [2:0] dcc_chan_t;

endpackage : dcc_pkg

//--- src/dcc_engine.sv
// eight-channel code path with shared gain and zero correction
`timescale 1ns/1ps
`include "dcc_defs.svh"

module dcc_engine #(
    parameter logic [15:0] TRIM_A_G6 = `DCC_TRIM_G6,
    parameter logic [15:0] TRIM_A_G4 = `DCC_TRIM_G4,
    parameter logic [15:0] TRIM_B_G6 = `DCC_TRIM_G6,
    parameter logic [15:0] TRIM_B_G4 = `DCC_TRIM_G4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // register port
    input wire dcc_pkg::dcc_addr_t addr,
    input wire dcc_pkg::dcc_code_t wdata,
    input wire logic wstb,
    input wire logic rstb,
    output dcc_pkg::dcc_code_t rdata,
    // pins
    input wire logic data_format_select_pin,
    input wire logic dual_supply,
    // converter side
    output dcc_pkg::dcc_code_t dac_code [`DCC_NUM_CH],
    output dcc_pkg::dcc_code_t offset_converter_code_a,
    output dcc_pkg::dcc_code_t offset_converter_code_b,
    output logic offset_powerdown,
    output logic engine_busy
);
    import dcc_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    dcc_code_t input_reg [`DCC_NUM_CH];
    dcc_code_t gain_reg [`DCC_NUM_CH];
    dcc_code_t zero_reg [`DCC_NUM_CH];
    dcc_code_t data_reg [`DCC_NUM_CH];
    dcc_code_t offset_a;
    dcc_code_t offset_b;
    logic correction_enable_bit;
    logic gain_four;
    logic [`DCC_NUM_CH-1:0] pending;
    logic [`DCC_NUM_CH-1:0] next_pending;
    dcc_state_e state;
    dcc_state_e next_state;
    dcc_chan_t work_ch;
    dcc_chan_t pick_ch;
    logic pick_any;
    logic [32:0] product;
    logic [16:0] scaled;
    logic signed [17:0] sum;
    dcc_code_t sat_code;
    dcc_code_t fmt_flip;
    dcc_code_t next_rdata;
    dcc_code_t cfg_word;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [3:0] rgn;
    dcc_chan_t ch;
    logic wr_input;
    logic wr_gain;
    logic wr_zero;
    logic wr_cfg;
    logic wr_off_a;
    logic wr_off_b;
    logic cfg_gain_new;

    assign rgn = addr[7:4];
    assign ch = addr[2:0];
    assign wr_input = wstb && (rgn == `DCC_RGN_INPUT) && !addr[3];
    assign wr_gain = wstb && (rgn == `DCC_RGN_GAIN) && !addr[3];
    assign wr_zero = wstb && (rgn == `DCC_RGN_ZERO) && !addr[3];
    assign wr_cfg = wstb && (addr == `DCC_ADDR_CONFIG);
    assign wr_off_a = wstb && (addr == `DCC_ADDR_OFFSET_A);
    assign wr_off_b = wstb && (addr == `DCC_ADDR_OFFSET_B);
    assign cfg_gain_new = wdata[`DCC_CFG_GAIN4_BIT];

    assign fmt_flip = data_format_select_pin ? `DCC_SIGN_FLIP : 16'h0000;

    // ------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------
    // enable and gain_four bits
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            correction_enable_bit <= 1'b0;
            gain_four <= 1'b0;
        end else if (wr_cfg) begin
            correction_enable_bit <= wdata[`DCC_CFG_ENABLE_BIT];
            gain_four <= cfg_gain_new;
        end
    end

    // ------------------------------------------------------------
    // per-channel registers
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `DCC_NUM_CH; gi++) begin : g_ch
            logic hit;
            assign hit = (ch == 3'(gi));

            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    input_reg[gi] <= `DCC_INPUT_RESET;
                end else if (wr_input && hit) begin
                    input_reg[gi] <= wdata;
                end
            end

            // gain and zero kept as written
            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    gain_reg[gi] <= `DCC_GAIN_RESET;
                    zero_reg[gi] <= `DCC_ZERO_RESET;
                end else begin
                    if (wr_gain && hit) begin
                        gain_reg[gi] <= wdata;
                    end
                    if (wr_zero && hit) begin
                        zero_reg[gi] <= wdata;
                    end
                end
            end

            always_ff @(posedge sys_clk) begin
                if (reset) begin
                    data_reg[gi] <= `DCC_DATA_RESET;
                end else if (!correction_enable_bit && wr_input
                             && hit) begin
                    data_reg[gi] <= wdata ^ fmt_flip;
                end else if (state == DCC_STORE
                             && work_ch == 3'(gi)) begin
                    data_reg[gi] <= sat_code;
                end
            end

            assign dac_code[gi] = data_reg[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // request queue
    // ------------------------------------------------------------
    always_comb begin
        next_pending = pending;
        if (state == DCC_IDLE && pick_any) begin
            next_pending[pick_ch] = 1'b0;
        end
        if (correction_enable_bit && (wr_input || wr_gain || wr_zero)) begin
            next_pending[ch] = 1'b1;
        end
        if (!correction_enable_bit) begin
            next_pending = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pending <= '0;
        end else begin
            pending <= next_pending;
        end
    end

    always_comb begin
        pick_any = 1'b0;
        pick_ch = 3'h0;
        for (int i = `DCC_NUM_CH - 1; i >= 0; i--) begin
            if (pending[i]) begin
                pick_any = 1'b1;
                pick_ch = 3'(i);
            end
        end
    end

    // ------------------------------------------------------------
    // shared engine
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            DCC_IDLE: begin
                if (pick_any) begin
                    next_state = DCC_MUL;
                end
            end
            DCC_MUL: begin
                next_state = DCC_STORE;
            end
            DCC_STORE: begin
                next_state = DCC_IDLE;
            end
            default: begin
                next_state = DCC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= DCC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            work_ch <= 3'h0;
        end else if (state == DCC_IDLE && pick_any) begin
            work_ch <= pick_ch;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            product <= '0;
        end else if (state == DCC_MUL) begin
            product <= 33'(input_reg[work_ch] ^ fmt_flip)
                       * 33'({1'b0, gain_reg[work_ch]} + `DCC_GAIN_BIAS);
        end
    end

    assign scaled = product[32:16];
    assign sum = $signed({1'b0, scaled})
                 + $signed({{2{zero_reg[work_ch][15]}}, zero_reg[work_ch]});

    always_comb begin
        if (sum < 0) begin
            sat_code = `DCC_SAT_MIN;
        end else if (sum > $signed({2'b00, `DCC_SAT_MAX})) begin
            sat_code = `DCC_SAT_MAX;
        end else begin
            sat_code = sum[15:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            engine_busy <= 1'b0;
        end else begin
            engine_busy <= (|next_pending) || (next_state != DCC_IDLE);
        end
    end

    // ------------------------------------------------------------
    // offset converters
    // ------------------------------------------------------------
    // offset A serves 0-3, B serves 4-7
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            offset_a <= TRIM_A_G6;
            offset_b <= TRIM_B_G6;
        end else if (wr_cfg && cfg_gain_new != gain_four) begin
            offset_a <= cfg_gain_new ? TRIM_A_G4 : TRIM_A_G6;
            offset_b <= cfg_gain_new ? TRIM_B_G4 : TRIM_B_G6;
        end else begin
            if (wr_off_a) begin
                offset_a <= wdata ^ fmt_flip;
            end
            if (wr_off_b) begin
                offset_b <= wdata ^ fmt_flip;
            end
        end
    end

    assign offset_converter_code_a = offset_a;
    assign offset_converter_code_b = offset_b;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            offset_powerdown <= 1'b1;
        end else begin
            offset_powerdown <= !dual_supply;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    assign cfg_word = {14'h0000, gain_four, correction_enable_bit};

    always_comb begin
        next_rdata = 16'h0000;
        if (addr == `DCC_ADDR_CONFIG) begin
            next_rdata = cfg_word;
        end else if (addr == `DCC_ADDR_STATUS) begin
            next_rdata = {15'h0000, engine_busy};
        end else if (addr == `DCC_ADDR_OFFSET_A) begin
            next_rdata = offset_a ^ fmt_flip;
        end else if (addr == `DCC_ADDR_OFFSET_B) begin
            next_rdata = offset_b ^ fmt_flip;
        end else if (addr[3]) begin
            next_rdata = 16'h0000;
        end else if (rgn == `DCC_RGN_INPUT) begin
            next_rdata = input_reg[ch];
        end else if (rgn == `DCC_RGN_GAIN) begin
            next_rdata = gain_reg[ch];
        end else if (rgn == `DCC_RGN_ZERO) begin
            next_rdata = zero_reg[ch];
        end else if (rgn == `DCC_RGN_DATA) begin
            // straight code back to pin coding
            next_rdata = data_reg[ch] ^ fmt_flip;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata <= 16'h0000;
        end else if (rstb) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 16'h0000;
        end
    end

endmodule : dcc_engine

//--- verification/dcc_assertions.sv
// assertions for the code correction engine
`timescale 1ns/1ps
`include "dcc_defs.svh"
module dcc_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // register port
    input wire dcc_pkg::dcc_addr_t addr,
    input wire dcc_pkg::dcc_code_t wdata,
    input wire logic wstb,
    input wire logic rstb,
    input wire dcc_pkg::dcc_code_t rdata,
    // pins
    input wire logic data_format_select_pin,
    input wire logic dual_supply,
    // converter side
    input wire dcc_pkg::dcc_code_t dac_code [`DCC_NUM_CH],
    input wire dcc_pkg::dcc_code_t offset_converter_code_a,
    input wire dcc_pkg::dcc_code_t offset_converter_code_b,
    input wire logic offset_powerdown,
    input wire logic engine_busy
);
    import dcc_pkg::*;
    logic en_q;
    logic g4_q;
    logic [127:0] dac_flat;
    dcc_code_t flip;
    assign flip = {data_format_select_pin, 15'h0000};
    dcc_chan_t wr_ch;
    dcc_code_t wr_val;
    logic cfg_g4;
    assign wr_ch = addr[2:0];
    assign wr_val = wdata ^ flip;
    assign cfg_g4 = wdata[`DCC_CFG_GAIN4_BIT];
    for (genvar i = 0; i < 8; i++) begin : g_flat
        assign dac_flat[16*i+:16] = dac_code[i];
    end
    // ----
    // shadow of the config bits
    // ----
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            en_q <= 1'b0;
            g4_q <= 1'b0;
        end else if (wstb && addr == `DCC_ADDR_CONFIG) begin
            en_q <= wdata[0];
            g4_q <= wdata[1];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence cfg_wr;
        wstb && addr == `DCC_ADDR_CONFIG;
    endsequence
    sequence chan_wr;
        wstb && addr[7:4] <= 4'h2 && !addr[3];
    endsequence
    property p_bypass;
        (chan_wr ##0 (addr[7:4] == 4'h0 && !en_q)) |=>
            dac_code[$past(wr_ch)] == $past(wr_val);
    endproperty
    property p_reload;
        (cfg_wr ##0 cfg_g4 != g4_q) |=>
            offset_converter_code_a ==
                ($past(cfg_g4) ? `DCC_TRIM_G4 : `DCC_TRIM_G6) &&
            offset_converter_code_b ==
                ($past(cfg_g4) ? `DCC_TRIM_G4 : `DCC_TRIM_G6);
    endproperty
    property p_offset;
        (wstb && addr == `DCC_ADDR_OFFSET_A) |=>
            offset_converter_code_a == $past(wr_val);
    endproperty
    reset_vals_a: assert property (disable iff (1'b0)
        reset |=> dac_flat == '0 && offset_powerdown &&
            offset_converter_code_a == `DCC_TRIM_G6)
        else $error("reset values wrong");
    rdata_idle_a: assert property (!rstb |=> rdata == 16'h0000)
        else $error("read data outside read slot");
    pwrdn_follow_a: assert property (!$past(reset) |->
        offset_powerdown == !$past(dual_supply))
        else $error("power-down not following supply");
    bypass_direct_a: assert property (p_bypass)
        else $error("bypass write not passed through");
    gz_no_calc_a: assert property (!en_q [*5] ##0 chan_wr
        ##0 addr[7:4] != 4'h0 |=> $stable(dac_flat) && !engine_busy)
        else $error("gain or zero write changed outputs");
    calc_start_a: assert property (en_q && !engine_busy
        ##0 chan_wr |-> ##[1:2] engine_busy)
        else $error("correction not started");
    gain_reload_a: assert property (p_reload)
        else $error("offset not reloaded on gain change");
    offset_write_a: assert property (p_offset)
        else $error("offset write coding wrong");
endmodule : dcc_checker

bind dcc_engine dcc_checker u_chk (.*);

//--- verification/dcc_host.sv
// register port master standing in for the host processor
`timescale 1ns/1ps
module dcc_host (
    // clock
    input wire logic sys_clk,
    // register port
    output dcc_pkg::dcc_addr_t addr,
    output dcc_pkg::dcc_code_t wdata,
    output logic wstb,
    output logic rstb,
    input wire dcc_pkg::dcc_code_t rdata
);
    import dcc_pkg::*;
    initial begin
        addr = 8'hFF;
        wdata = 16'h0000;
        wstb = 1'b0;
        rstb = 1'b0;
    end
    task automatic wr(input dcc_addr_t a, input dcc_code_t d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wstb <= 1'b1;
        @(posedge sys_clk);
        wstb <= 1'b0;
        wdata <= ~d;
    endtask : wr
    task automatic rd(input dcc_addr_t a, output dcc_code_t d);
        @(posedge sys_clk);
        addr <= a;
        rstb <= 1'b1;
        @(posedge sys_clk);
        rstb <= 1'b0;
        addr <= ~a;
        @(posedge sys_clk);
        d = rdata;
    endtask : rd
endmodule : dcc_host

//--- verification/tb.sv
// self-checking bench for the code correction engine
`timescale 1ns/1ps
`include "dcc_defs.svh"
module tb;
    import dcc_pkg::*;
    logic sys_clk, reset, fmt, dual, wstb, rstb, pdn, busy;
    dcc_addr_t addr;
    dcc_code_t wdata, rdata, off_a, off_b, r;
    dcc_code_t dac_code [`DCC_NUM_CH];
    logic [3:0] c;
    int bad_count, comparisons;
    dcc_host host (.sys_clk(sys_clk), .addr(addr), .wdata(wdata),
        .wstb(wstb), .rstb(rstb), .rdata(rdata));
    dcc_engine dut (.sys_clk(sys_clk), .reset(reset), .addr(addr),
        .wdata(wdata), .wstb(wstb), .rstb(rstb), .rdata(rdata),
        .data_format_select_pin(fmt), .dual_supply(dual),
        .dac_code(dac_code), .offset_converter_code_a(off_a),
        .offset_converter_code_b(off_b), .offset_powerdown(pdn),
        .engine_busy(busy));
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input dcc_code_t got, input dcc_code_t exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    function automatic dcc_code_t corr(dcc_code_t i, g, z);
        longint p;
        p = ((longint'(i) * (longint'(g) + 32768)) >>> 16) +
            longint'($signed(z));
        return (p < 0) ? 16'h0000 : (p > 65535) ? 16'hFFFF : p[15:0];
    endfunction : corr
    task automatic wait_idle;
        int n;
        n = 0;
        repeat (2) @(posedge sys_clk);
        while (busy !== 1'b0) begin
            @(posedge sys_clk);
            n++;
            if (n > 100) begin
                bad_count++;
                $display("unexpected at %0t: engine hang", $time);
                complete_run();
            end
        end
        @(posedge sys_clk);
        #1;
    endtask : wait_idle
    task automatic t_reset;
        for (c = 0; c < 8; c++) begin
            host.rd({4'h0, c}, r);
            chk(r, 16'h0000);
            host.rd({4'h1, c}, r);
            chk(r, 16'h8000);
            host.rd({4'h2, c}, r);
            chk(r, 16'h0000);
            chk(dac_code[c], 16'h0000);
        end
        host.rd(`DCC_ADDR_OFFSET_B, r);
        chk(r, 16'h999A);
        chk({15'h0000, pdn}, 16'h0000);
        host.rd(8'h48, r);
        chk(r, 16'h0000);
        $display("reset test done");
    endtask : t_reset
    task automatic t_bypass;
        dcc_code_t v;
        for (int f = 0; f < 2; f++) begin
            @(posedge sys_clk);
            fmt <= f[0];
            for (c = 0; c < 8; c++) begin
                v = {c[1:0], 14'h0000} ^ {16{c[2]}};
                host.wr({4'h0, c}, v);
                #1;
                chk(dac_code[c], v ^ {f[0], 15'h0000});
                host.rd({4'h3, c}, r);
                chk(r, v);
            end
        end
        $display("bypass test done");
    endtask : t_bypass
    task automatic t_gz;
        dcc_code_t d;
        for (c = 0; c < 8; c++) begin
            d = dac_code[c];
            host.wr({4'h1, c}, {12'hA5A, c});
            host.wr({4'h2, c}, 16'h8001);
            #1;
            chk(dac_code[c], d);
            host.rd({4'h1, c}, r);
            chk(r, {12'hA5A, c});
            host.rd({4'h2, c}, r);
            chk(r, 16'h8001);
        end
        $display("gain zero test done");
    endtask : t_gz
    task automatic t_correct;
        dcc_code_t ti [4] = '{16'hFFFF, 16'h1000, 16'h8000, 16'h4000};
        dcc_code_t tg [4] = '{16'hFFFF, 16'h0000, 16'h8000, 16'hFFFF};
        dcc_code_t tz [4] = '{16'h7FFF, 16'h8000, 16'h0010, 16'hFFFF};
        @(posedge sys_clk);
        fmt <= 1'b0;
        host.wr(`DCC_ADDR_CONFIG, 16'h0001);
        for (c = 0; c < 4; c++) begin
            host.wr({4'h1, c}, tg[c]);
            host.wr({4'h2, c}, tz[c]);
            host.wr({4'h0, c}, ti[c]);
            wait_idle();
            chk(dac_code[c], corr(ti[c], tg[c], tz[c]));
        end
        host.wr(8'h12, 16'h0000);
        wait_idle();
        chk(dac_code[2], corr(16'h8000, 16'h0000, 16'h0010));
        fmt <= 1'b1;
        host.wr(8'h02, 16'h7FFF);
        wait_idle();
        chk(dac_code[2], corr(16'hFFFF, 16'h0000, 16'h0010));
        host.wr(8'h04, 16'h2000);
        host.wr(8'h05, 16'h3000);
        host.rd(`DCC_ADDR_STATUS, r);
        chk(r, 16'h0001);
        wait_idle();
        chk(dac_code[4], corr(16'hA000, 16'hA5A4, 16'h8001));
        chk(dac_code[5], corr(16'hB000, 16'hA5A5, 16'h8001));
        host.rd(`DCC_ADDR_STATUS, r);
        chk(r, 16'h0000);
        host.rd(8'h35, r);
        chk(r, corr(16'hB000, 16'hA5A5, 16'h8001) ^ 16'h8000);
        host.wr(`DCC_ADDR_CONFIG, 16'h0000);
        $display("correction test done");
    endtask : t_correct
    task automatic t_offsets;
        host.wr(`DCC_ADDR_OFFSET_A, 16'h1234);
        #1;
        chk(off_a, 16'h9234);
        host.rd(`DCC_ADDR_OFFSET_A, r);
        chk(r, 16'h1234);
        host.wr(`DCC_ADDR_OFFSET_B, 16'h0000);
        #1;
        chk(off_b, 16'h8000);
        host.rd(`DCC_ADDR_OFFSET_B, r);
        chk(r, 16'h0000);
        host.wr(`DCC_ADDR_CONFIG, 16'h0002);
        #1;
        chk(off_a, 16'hAAAB);
        chk(off_b, 16'hAAAB);
        host.wr(`DCC_ADDR_CONFIG, 16'h0000);
        #1;
        chk(off_a, 16'h999A);
        chk(off_b, 16'h999A);
        @(posedge sys_clk);
        dual <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk({15'h0000, pdn}, 16'h0001);
        dual <= 1'b1;
        $display("offset test done");
    endtask : t_offsets
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        bad_count = 0;
        comparisons = 0;
        reset = 1'b1;
        fmt = 1'b0;
        dual = 1'b1;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_bypass();
        t_gz();
        t_correct();
        t_offsets();
        complete_run();
    end
endmodule : tb
